// File: hw/supervisor_defs.svh
// Purpose: Shared constants of the supply and thermal supervisor.
// Assumes: 125 MHz clock, 16-bit link words, 32-bit Wishbone.
// Notes: Times are in ns; cycle counts are derived from them.
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

`define LIN_NUM 3
`define CLK_PERIOD_NS 8
`define CNT_W 20
`define AUX_CNT_W 10

// Least reset delay, short filter, auxiliary rail filter
`define RESET_DELAY_NS 1500000
`define SHORT_FILTER_NS 4000000
`define AUX_FILTER_NS 7000
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_DELAY_CYC `NS_TO_CYC(`RESET_DELAY_NS)
`define SHORT_FILTER_CYC `NS_TO_CYC(`SHORT_FILTER_NS)
`define AUX_FILTER_CYC `NS_TO_CYC(`AUX_FILTER_NS)

// Device register indexes on the link
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_FAULT 2'h2

// Control word fields
`define CTRL_MODE_LO 0
`define CTRL_WD_BUS 2
`define CTRL_THR_LO 3
`define CTRL_HIGH_RST 5
`define CTRL_AUX_ON 6
`define MODE_REQ_NORMAL 2'h0
`define MODE_REQ_STOP 2'h1
`define MODE_REQ_SLEEP 2'h2
`define MODE_REQ_NONE 2'h3
`define THRESH_OFF 2'h3

// Status flag positions
`define FLAG_W 10
`define FL_POR 0
`define FL_LIN_LOW 1
`define FL_MAIN_LOW 2
`define FL_MAIN_HIGH 3
`define FL_MAIN_SHORT 4
`define FL_BUCK_SHORTED 5
`define FL_AUX_LOW 6
`define FL_BLOCK_HOT 7
`define FL_AUX_HOT 8
`define FL_PREWARN 9

// Host Wishbone word indexes (adr[3:2])
`define WB_DEV_CTRL 2'h0
`define WB_DEV_STATUS 2'h1
`define WB_DEV_FAULT 2'h2
`define WB_LOCAL 2'h3
`define LOCAL_WAKE_SEEN 5

`endif

// File: hw/supervisor_pkg.sv
// Purpose: Types shared by both ends of the supervisor link.
// Assumes: supervisor_defs.svh supplies the widths.
// Notes: First enum member of each type is its reset state.
`include "supervisor_defs.svh"

package supervisor_pkg;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_INIT, MODE_NORMAL, MODE_STOP,
      MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
   } sbc_mode_t;

   typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_ACK} host_state_t;

   typedef struct packed {
      logic supplyAbovePor;
      logic [2:0] mainAboveRt;
      logic mainHigh;
      logic vsAboveTimeout;
      logic linSupplyLow;
      logic auxLow;
      logic auxRamping;
      logic canHot;
      logic [`LIN_NUM-1:0] linHot;
      logic auxHot;
      logic buckPrewarn;
      logic canWake;
      logic [`LIN_NUM-1:0] linWake;
      logic wakeInput;
   } sense_t;

   typedef struct packed {
      sense_t syncA;
      sense_t syncB;
      sbc_mode_t mode;
      logic resetOutN;
      logic [`CNT_W-1:0] delayCnt;
      logic [`CNT_W-1:0] shortCnt;
      logic [`AUX_CNT_W-1:0] auxCnt;
      logic wdBus;
      logic [1:0] thrSel;
      logic highReset;
      logic auxOn;
      logic [`FLAG_W-1:0] flags;
      logic canFault;
      logic [`LIN_NUM-1:0] linFault;
      logic canRxLow;
      logic [`LIN_NUM-1:0] linRxLow;
      logic canRxOut;
      logic [`LIN_NUM-1:0] linRxOut;
      logic [15:0] rdData;
      logic wakeIrq;
      logic wdRestart;
   } dev_state_t;

   typedef struct packed {
      host_state_t state;
      logic [1:0] addr;
      logic write;
      logic [15:0] data;
      logic [31:0] datOut;
      logic wakeSeen;
   } host_reg_t;

endpackage : supervisor_pkg

// File: hw/supervisor_link.sv
// Purpose: Link between the supervisor device and its host.
// Assumes: One clock shared by both ends, supplied outside.
// Notes: Command strobe is one cycle; read data follows one edge later.
`include "supervisor_defs.svh"

interface supervisor_link;
   logic cmdValid;
   logic cmdWrite;
   logic [1:0] cmdAddr;
   logic [15:0] cmdData;
   logic [15:0] rdData;
   logic resetOutN;
   logic wakeIrq;
   logic canReceiveOut;
   logic [`LIN_NUM-1:0] linReceiveOut;

   modport dev (
      input cmdValid, cmdWrite, cmdAddr, cmdData,
      output rdData, resetOutN, wakeIrq, canReceiveOut, linReceiveOut
   );
   modport mcu (
      output cmdValid, cmdWrite, cmdAddr, cmdData,
      input rdData, resetOutN, wakeIrq, canReceiveOut, linReceiveOut
   );
endinterface : supervisor_link

// File: hw/supply_thermal_supervisor.sv
// Purpose: Supply, reset and thermal supervision of the basis chip.
// Assumes: Comparator levels arrive unsynchronised in sense.
// Notes: Supply loss acts as a reset of all register state but the input synchronisers.
// How it works
// - Host changes bus-wake start only in normal
// - Bus wake in stop restarts watchdog
// - Bus wake raises interrupt, pulls receive low
// - Host re-sends disabling sequence after restart
// - Power-on sets startup flag, loads defaults
// - Reset held until rail up plus delay
// - Supply loss resets chip; restart in init
// - LIN supply low: flag and receive-only
// - Rail undervoltage: reset, restart, flag
// - Threshold select 11 disables undervoltage
// - No rail low flag in sleep, fail-safe
// - Overvoltage watched in init, normal, stop
// - Overvoltage with enable enters restart mode
// - Long short: fail-safe, buck off, flags
// - Status flags trigger no mode change
// - Auxiliary rail low after filter, sticky
// - Block overheat switches block off, flags
// - Auxiliary overheat clears its on control in normal, or in stop with watchdog on
// - CAN overheat: receive-only, fault code 01
// - LIN overheat: receive-only, fault code 01
// - Thermal flags stay until host clears
// - Buck prewarning flag while buck on
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`include "supervisor_defs.svh"

module supply_thermal_supervisor #(
   parameter int unsigned RESET_DELAY_CYC = `RESET_DELAY_CYC,
   parameter int unsigned SHORT_FILTER_CYC = `SHORT_FILTER_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host link
   supervisor_link.dev link,
   // Analog comparators and wake detectors
   input wire supervisor_pkg::sense_t sense,
   // Block state from the rest of the chip
   input wire logic wdOffInStop,
   input wire logic canActive,
   input wire logic [`LIN_NUM-1:0] linActive,
   input wire logic canRxIn,
   input wire logic [`LIN_NUM-1:0] linRxIn,
   // Controls to the rest of the chip
   output logic buckEnable,
   output logic auxRailEnable,
   output logic failsafeOutputs,
   output logic canTxDisable,
   output logic [`LIN_NUM-1:0] linTxDisable,
   output logic wdRestartLong
);
   import supervisor_pkg::*;

   // Mode OFF is code zero, so all-zero is the power-on state
   localparam dev_state_t DEV_RESET = '0;

   dev_state_t s;
   dev_state_t n;
   sense_t c;
   logic railUp;
   logic uvEnabled;
   logic powered;
   logic ovWatched;
   logic busWake;
   logic anyWake;
   logic auxGuard;
   logic [`FLAG_W-1:0] hold;
   logic [`FLAG_W-1:0] clr;
   logic [`LIN_NUM-1:0] linHotOn;

   function automatic logic released(input dev_state_t st,
                                     input logic up);
      released = up && (st.delayCnt ==
                        `CNT_W'(RESET_DELAY_CYC - 1));
   endfunction : released

   always_comb begin
      n = s;
      n.syncA = sense;
      n.syncB = s.syncA;
      c = s.syncB;
      n.wakeIrq = 1'b0;
      n.wdRestart = 1'b0;
      clr = '0;
      uvEnabled = (s.thrSel != `THRESH_OFF);
      railUp = c.mainAboveRt[uvEnabled ? s.thrSel : 2'h0];
      powered = (s.mode != MODE_OFF) && (s.mode != MODE_SLEEP) &&
                (s.mode != MODE_FAILSAFE);
      ovWatched = (s.mode == MODE_INIT) || (s.mode == MODE_NORMAL) ||
                  (s.mode == MODE_STOP);
      busWake = c.canWake || (|c.linWake);
      anyWake = busWake || c.wakeInput;
      linHotOn = linActive & c.linHot;
      // Flags that may only be cleared once their cause is gone
      hold = '0;
      hold[`FL_LIN_LOW] = c.linSupplyLow;
      hold[`FL_BLOCK_HOT] = c.canHot || (|c.linHot) || c.auxHot;
      hold[`FL_AUX_HOT] = c.auxHot;
      hold[`FL_PREWARN] = c.buckPrewarn;

      // Host commands go first so that hardware sets below win
      if (link.cmdValid && !link.cmdWrite) begin
         case (link.cmdAddr)
            `REG_CTRL: n.rdData = {5'h00, s.mode, 1'b0, s.auxOn,
                                   s.highReset, s.thrSel, s.wdBus, 2'h0};
            `REG_STATUS: n.rdData = {6'h00, s.flags};
            `REG_FAULT: n.rdData = {8'h00, 1'b0, s.linFault[2], 1'b0,
                                    s.linFault[1], 1'b0, s.linFault[0],
                                    1'b0, s.canFault};
            default: n.rdData = 16'h0000;
         endcase
      end
      if (link.cmdValid && link.cmdWrite) begin
         case (link.cmdAddr)
            `REG_CTRL: begin
               n.thrSel = link.cmdData[`CTRL_THR_LO +: 2];
               n.highReset = link.cmdData[`CTRL_HIGH_RST];
               n.auxOn = link.cmdData[`CTRL_AUX_ON];
               n.canRxLow = 1'b0;
               n.linRxLow = '0;
               if (s.mode == MODE_NORMAL) begin
                  n.wdBus = link.cmdData[`CTRL_WD_BUS];
               end
               case (link.cmdData[`CTRL_MODE_LO +: 2])
                  `MODE_REQ_NORMAL: begin
                     if (s.resetOutN && (ovWatched)) begin
                        n.mode = MODE_NORMAL;
                     end
                  end
                  `MODE_REQ_STOP: begin
                     if (s.mode == MODE_NORMAL) begin
                        n.mode = MODE_STOP;
                     end
                  end
                  `MODE_REQ_SLEEP: begin
                     if ((s.mode == MODE_NORMAL) ||
                         (s.mode == MODE_STOP)) begin
                        n.mode = MODE_SLEEP;
                        n.resetOutN = 1'b0;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            `REG_STATUS: clr = link.cmdData[`FLAG_W-1:0] & ~hold;
            `REG_FAULT: begin
               if (link.cmdData[0] && !c.canHot) begin
                  n.canFault = 1'b0;
               end
               for (int i = 0; i < `LIN_NUM; i++) begin
                  if (link.cmdData[2 * i + 2] && !c.linHot[i]) begin
                     n.linFault[i] = 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      // Flags fall only on a host clear
      n.flags = s.flags & ~clr;

      case (s.mode)
         MODE_OFF: begin
            n.mode = MODE_INIT;
            n.flags[`FL_POR] = 1'b1;
            n.delayCnt = '0;
         end
         MODE_INIT, MODE_RESTART: begin
            if (!s.resetOutN) begin
               if (!railUp) begin
                  n.delayCnt = '0;
               end else if (released(s, railUp)) begin
                  n.resetOutN = 1'b1;
                  n.delayCnt = '0;
               end else begin
                  n.delayCnt = s.delayCnt + 20'h0_0001;
               end
            end else if (s.mode == MODE_RESTART &&
                         !(s.highReset && c.mainHigh)) begin
               n.mode = MODE_NORMAL;
            end
         end
         MODE_SLEEP, MODE_FAILSAFE: begin
            if (anyWake) begin
               n.mode = MODE_RESTART;
               n.delayCnt = '0;
            end
         end
         MODE_NORMAL, MODE_STOP: begin
         end
         default: n.mode = MODE_OFF;
      endcase

      if (ovWatched && c.mainHigh) begin
         n.flags[`FL_MAIN_HIGH] = 1'b1;
         if (s.highReset) begin
            n.mode = MODE_RESTART;
            n.resetOutN = 1'b0;
            n.delayCnt = '0;
         end
      end
      if (uvEnabled && powered && s.resetOutN && !railUp) begin
         n.flags[`FL_MAIN_LOW] = 1'b1;
         n.mode = MODE_RESTART;
         n.resetOutN = 1'b0;
         n.delayCnt = '0;
      end
      if (powered && !railUp && c.vsAboveTimeout) begin
         n.shortCnt = s.shortCnt + 20'h0_0001;
         if (s.shortCnt == `CNT_W'(SHORT_FILTER_CYC - 1)) begin
            n.mode = MODE_FAILSAFE;
            n.resetOutN = 1'b0;
            n.shortCnt = '0;
            n.flags[`FL_MAIN_SHORT] = 1'b1;
            n.flags[`FL_MAIN_LOW] = 1'b1;
            n.flags[`FL_BUCK_SHORTED] = 1'b1;
         end
      end else begin
         n.shortCnt = '0;
      end

      if (c.linSupplyLow) begin
         n.flags[`FL_LIN_LOW] = 1'b1;
      end
      if (s.auxOn && c.auxLow && !c.auxRamping) begin
         if (s.auxCnt == `AUX_CNT_W'(`AUX_FILTER_CYC - 1)) begin
            n.flags[`FL_AUX_LOW] = 1'b1;
         end else begin
            n.auxCnt = s.auxCnt + 10'h001;
         end
      end else begin
         n.auxCnt = '0;
      end
      auxGuard = (s.mode == MODE_NORMAL) ||
                 (s.mode == MODE_STOP && !wdOffInStop);
      if (s.auxOn && auxGuard && c.auxHot) begin
         n.auxOn = 1'b0;
         n.flags[`FL_AUX_HOT] = 1'b1;
         n.flags[`FL_BLOCK_HOT] = 1'b1;
      end
      if (canActive && c.canHot) begin
         n.canFault = 1'b1;
         n.flags[`FL_BLOCK_HOT] = 1'b1;
      end
      if (|linHotOn) begin
         n.linFault = s.linFault | linHotOn;
         n.flags[`FL_BLOCK_HOT] = 1'b1;
      end
      if (powered && c.buckPrewarn) begin
         n.flags[`FL_PREWARN] = 1'b1;
      end

      if (c.canWake) begin
         n.canRxLow = 1'b1;
      end
      n.linRxLow = n.linRxLow | c.linWake;
      n.wakeIrq = busWake;
      // Long open window on bus wake
      if (s.mode == MODE_STOP && s.wdBus && wdOffInStop && busWake) begin
         n.wdRestart = 1'b1;
      end
      n.canRxOut = canRxIn && !n.canRxLow;
      n.linRxOut = linRxIn & ~n.linRxLow;

      // Supply loss resets all state but the input synchronisers
      if (!c.supplyAbovePor) begin
         n = DEV_RESET;
         n.syncA = sense;
         n.syncB = s.syncA;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= DEV_RESET;
      end else begin
         s <= n;
      end
   end

   assign link.rdData = s.rdData;
   assign link.resetOutN = s.resetOutN;
   assign link.wakeIrq = s.wakeIrq;
   assign link.canReceiveOut = s.canRxOut;
   assign link.linReceiveOut = s.linRxOut;
   assign buckEnable = powered;
   assign auxRailEnable = s.auxOn;
   assign failsafeOutputs = (s.mode == MODE_FAILSAFE);
   assign canTxDisable = canActive && s.syncB.canHot;
   assign linTxDisable = (linActive & s.syncB.linHot) |
                         {`LIN_NUM{s.syncB.linSupplyLow}};
   assign wdRestartLong = s.wdRestart;

endmodule : supply_thermal_supervisor

// File: hw/supervisor_host.sv
// Purpose: Host end: Wishbone slave that relays to the supervisor link.
// Assumes: Classic single-cycle Wishbone master, 32-bit data.
// Notes: Disabling sequence after a bus-wake restart is software work.
`include "supervisor_defs.svh"

module supervisor_host (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [3:0] wbSel,
   input wire logic [3:0] wbAdr,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   // Link to the supervisor
   supervisor_link.mcu link
);
   import supervisor_pkg::*;

   localparam host_reg_t HOST_RESET = '0;

   host_reg_t s;
   host_reg_t n;
   logic [15:0] laneMask;

   always_comb begin
      n = s;
      laneMask = {{8{wbSel[1]}}, {8{wbSel[0]}}};
      // Wake sticky bit; a wake in the clearing cycle survives
      if (s.state == H_IDLE && wbCyc && wbStb && wbWe && wbSel[0] &&
          wbAdr[3:2] == `WB_LOCAL && wbDatIn[`LOCAL_WAKE_SEEN]) begin
         n.wakeSeen = 1'b0;
      end
      if (link.wakeIrq) begin
         n.wakeSeen = 1'b1;
      end
      case (s.state)
         H_IDLE: begin
            if (wbCyc && wbStb) begin
               if (wbAdr[3:2] == `WB_LOCAL) begin
                  n.datOut = {26'h000_0000, s.wakeSeen, link.linReceiveOut,
                              link.canReceiveOut, link.resetOutN};
                  n.state = H_ACK;
               end else begin
                  n.addr = wbAdr[3:2];
                  n.write = wbWe;
                  n.data = wbDatIn[15:0] & laneMask;
                  n.state = H_SEND;
               end
            end
         end
         H_SEND: n.state = H_WAIT;
         H_WAIT: begin
            n.datOut = {16'h0000, link.rdData};
            n.state = H_ACK;
         end
         H_ACK: n.state = H_IDLE;
         default: n.state = H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= HOST_RESET;
      end else begin
         s <= n;
      end
   end

   // Each command relayed as one strobe
   assign link.cmdValid = (s.state == H_SEND);
   assign link.cmdWrite = s.write;
   assign link.cmdAddr = s.addr;
   assign link.cmdData = s.data;
   assign wbAck = (s.state == H_ACK);
   assign wbDatOut = s.datOut;

endmodule : supervisor_host

// File: test/supervisor_sva.sv
// Purpose: Assertions on the supervisor link and its device-side pins.
// Assumes: The bench always moves the three rail comparators together.
// Notes: Threshold and overvoltage fields are tracked from CTRL writes.
`include "supervisor_defs.svh"

module supervisor_sva #(
   parameter int unsigned RESET_DELAY_CYC = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [1:0] cmdAddr,
   input wire logic [15:0] cmdData,
   input wire logic resetOutN,
   input wire logic wakeIrq,
   input wire logic canReceiveOut,
   // Device side
   input wire supervisor_pkg::sense_t sense,
   input wire logic canActive,
   input wire logic canTxDisable,
   input wire logic [`LIN_NUM-1:0] linTxDisable
);
   logic [1:0] selReg;
   logic highRst;
   logic [15:0] upCnt;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Supply loss wipes the device registers, so the copies go too
   always_ff @(posedge clk) begin
      if (!rst_n || !sense.supplyAbovePor) begin
         selReg <= 2'h0;
         highRst <= 1'b0;
         upCnt <= 16'h0000;
      end else begin
         if (cmdValid && cmdWrite && cmdAddr == 2'h0) begin
            selReg <= cmdData[4:3];
            highRst <= cmdData[5];
         end
         if (!sense.mainAboveRt[0]) begin
            upCnt <= 16'h0000;
         end else if (upCnt != 16'hffff) begin
            upCnt <= upCnt + 16'h0001;
         end
      end
   end

   sequence s_bus_wake;
      resetOutN && (sense.canWake || |sense.linWake);
   endsequence
   sequence s_rail_lost;
      resetOutN && sense.supplyAbovePor && sense.mainAboveRt == 3'h0 &&
         selReg != 2'h3;
   endsequence

   property p_wake_irq;
      s_bus_wake |-> ##[1:4] wakeIrq;
   endproperty
   a_wake_irq: assert property (p_wake_irq)
      else $error("no wake interrupt");
   property p_wake_rx;
      resetOutN && sense.canWake |-> ##[1:4] !canReceiveOut;
   endproperty
   a_wake_rx: assert property (p_wake_rx)
      else $error("CAN receive not low");
   property p_power_loss;
      !sense.supplyAbovePor |-> ##[1:4] !resetOutN;
   endproperty
   a_power_loss: assert property (p_power_loss)
      else $error("no reset on supply loss");
   property p_reset_delay;
      $rose(resetOutN) |-> upCnt >= RESET_DELAY_CYC;
   endproperty
   a_reset_delay: assert property (p_reset_delay)
      else $error("early reset release");
   property p_uv_reset;
      s_rail_lost |-> ##[1:4] !resetOutN;
   endproperty
   a_uv_reset: assert property (p_uv_reset)
      else $error("no undervoltage reset");
   property p_ov_reset;
      resetOutN && highRst && sense.mainHigh |-> ##[1:4] !resetOutN;
   endproperty
   a_ov_reset: assert property (p_ov_reset)
      else $error("no overvoltage reset");
   property p_can_hot;
      canActive && sense.canHot |-> ##[1:3] canTxDisable;
   endproperty
   a_can_hot: assert property (p_can_hot)
      else $error("CAN transmitter on while hot");
   property p_can_cool;
      !sense.canHot [*3] |-> !canTxDisable;
   endproperty
   a_can_cool: assert property (p_can_cool)
      else $error("CAN transmitter off after cooling");
   property p_lin_supply;
      sense.linSupplyLow |-> ##[1:3] (&linTxDisable);
   endproperty
   a_lin_supply: assert property (p_lin_supply)
      else $error("LIN not receive-only");
endmodule : supervisor_sva

// File: test/test_supply_thermal_supervisor.sv
// Purpose: Self-checking bench of the supervisor and its host end.
// Assumes: Shortened reset delay and short filter parameters.
// Notes: Registers reached over Wishbone via the host end.
`include "supervisor_defs.svh"

module test_supply_thermal_supervisor;
   timeunit 1ns;
   timeprecision 1ps;
   import supervisor_pkg::*;
   // Short filter above reset delay: undervoltage first
   localparam int RDLY = 20;
   localparam int SFLT = 40;
   localparam logic [3:0] CT = 4'h0;
   localparam logic [3:0] ST = 4'h4;
   localparam logic [3:0] FT = 4'h8;
   localparam logic [3:0] LC = 4'hc;
   logic clk = 1'b0, rst_n = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [3:0] wbSel = 4'h0;
   logic [3:0] wbAdr = 4'h0;
   logic [31:0] wbDatIn = 32'h0000_0000;
   logic [31:0] wbDatOut, q;
   sense_t sense;
   logic wdOffInStop = 1'b0, canActive = 1'b0, canRxIn = 1'b1;
   logic [`LIN_NUM-1:0] linActive = 3'h0;
   logic [`LIN_NUM-1:0] linRxIn = 3'h7;
   logic buckEnable, auxRailEnable, failsafeOutputs, canTxDisable, wbAck;
   logic [`LIN_NUM-1:0] linTxDisable;
   logic wdRestartLong;
   int n_errors = 0;
   int num_checks = 0;

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
 $display("ERROR %0t: got %h want %h", $time, g, e); end end

   always #4 clk = ~clk;

   supervisor_link link();
   supply_thermal_supervisor #(.RESET_DELAY_CYC(RDLY),
      .SHORT_FILTER_CYC(SFLT)) i_supply_thermal_supervisor (
      .clk(clk), .rst_n(rst_n), .link(link.dev), .sense(sense),
      .wdOffInStop(wdOffInStop), .canActive(canActive),
      .linActive(linActive), .canRxIn(canRxIn), .linRxIn(linRxIn),
      .buckEnable(buckEnable), .auxRailEnable(auxRailEnable),
      .failsafeOutputs(failsafeOutputs), .canTxDisable(canTxDisable),
      .linTxDisable(linTxDisable), .wdRestartLong(wdRestartLong));
   supervisor_host i_supervisor_host (
      .clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatIn(wbDatIn),
      .wbDatOut(wbDatOut), .wbAck(wbAck), .link(link.mcu));
   supervisor_sva #(.RESET_DELAY_CYC(RDLY)) i_supervisor_sva (
      .clk(clk), .rst_n(rst_n), .cmdValid(link.cmdValid),
      .cmdWrite(link.cmdWrite), .cmdAddr(link.cmdAddr),
      .cmdData(link.cmdData), .resetOutN(link.resetOutN),
      .wakeIrq(link.wakeIrq), .canReceiveOut(link.canReceiveOut),
      .sense(sense), .canActive(canActive),
      .canTxDisable(canTxDisable), .linTxDisable(linTxDisable));

   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w

   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [15:0] d);
      int t;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbSel <= 4'hf;
      wbAdr <= a;
      wbDatIn <= {16'h0000, d};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1 && t < 20);
      if (wbAck !== 1'b1) begin
         n_errors++;
         test_done();
      end
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb

   task automatic rd(input logic [3:0] a);
      wb(1'b0, a, 16'h0000);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      wb(1'b1, a, d);
   endtask : wr

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   task automatic t_power_up;
      w(RDLY - 4);
      `CHK(link.resetOutN, 1'b0)
      w(12);
      `CHK(link.resetOutN, 1'b1)
      rd(ST);
      `CHK(q[`FL_POR], 1'b1)
      rd(CT);
      `CHK(q[10:2], {MODE_INIT, 6'h00})
      wr(ST, 16'h03ff);
      wr(CT, 16'h0000);
   endtask : t_power_up

   task automatic t_uv;
      wr(CT, 16'h001b);
      sense.mainAboveRt <= 3'h0;
      w(10);
      rd(ST);
      `CHK({link.resetOutN, q[`FL_MAIN_LOW]}, 2'b10)
      sense.mainAboveRt <= 3'h7;
      wr(CT, 16'h0003);
      sense.mainAboveRt <= 3'h0;
      w(6);
      `CHK(link.resetOutN, 1'b0)
      rd(CT);
      `CHK(q[10:8], MODE_RESTART)
      rd(ST);
      `CHK(q[`FL_MAIN_LOW], 1'b1)
      sense.mainAboveRt <= 3'h7;
      w(RDLY + 10);
      rd(CT);
      `CHK(q[10:8], MODE_NORMAL)
      wr(ST, 16'h03ff);
   endtask : t_uv

   task automatic t_short;
      sense.vsAboveTimeout <= 1'b1;
      sense.mainAboveRt <= 3'h0;
      w(SFLT + 10);
      `CHK({buckEnable, failsafeOutputs}, 2'b01)
      rd(ST);
      `CHK(q[5:2], 4'b1101)
      wr(ST, 16'h03ff);
      rd(ST);
      `CHK(q[`FL_MAIN_LOW], 1'b0)
      sense.vsAboveTimeout <= 1'b0;
      sense.mainAboveRt <= 3'h7;
      sense.wakeInput <= 1'b1;
      w(1);
      sense.wakeInput <= 1'b0;
      w(RDLY + 10);
      rd(CT);
      `CHK(q[10:8], MODE_NORMAL)
   endtask : t_short

   task automatic t_ov;
      wr(CT, 16'h0023);
      sense.mainHigh <= 1'b1;
      w(6);
      rd(ST);
      `CHK({link.resetOutN, q[`FL_MAIN_HIGH]}, 2'b01)
      sense.mainHigh <= 1'b0;
      w(RDLY + 10);
      rd(CT);
      `CHK(q[10:8], MODE_NORMAL)
      wr(CT, 16'h0003);
      wr(ST, 16'h03ff);
      sense.mainHigh <= 1'b1;
      w(6);
      rd(ST);
      `CHK({link.resetOutN, q[`FL_MAIN_HIGH]}, 2'b11)
      sense.mainHigh <= 1'b0;
      w(3);
      wr(ST, 16'h03ff);
   endtask : t_ov

   task automatic t_wake;
      logic irq, wd;
      logic [3:0] e;
      wr(CT, 16'h0004);
      wr(CT, 16'h0005);
      wdOffInStop <= 1'b1;
      // Enable change ignored outside normal
      wr(CT, 16'h0003);
      rd(CT);
      `CHK(q[10:2], {MODE_STOP, 6'h01})
      for (int i = 0; i < 4; i++) begin
         irq = 1'b0;
         wd = 1'b0;
         e = (i == 3) ? 4'b0111 : {1'b1, ~(3'b001 << i)};
         if (i == 3) begin
            sense.canWake <= 1'b1;
         end else begin
            sense.linWake[i] <= 1'b1;
         end
         @(posedge clk);
         sense.canWake <= 1'b0;
         sense.linWake <= 3'h0;
         repeat (6) begin
            @(posedge clk);
            irq = irq | link.wakeIrq;
            wd = wd | wdRestartLong;
         end
         `CHK({irq, wd}, 2'b11)
         `CHK({link.canReceiveOut, link.linReceiveOut}, e)
         wr(CT, 16'h0003);
      end
      rd(LC);
      `CHK(q[`LOCAL_WAKE_SEEN], 1'b1)
      wr(LC, 16'h0020);
      rd(LC);
      `CHK(q[`LOCAL_WAKE_SEEN], 1'b0)
      wdOffInStop <= 1'b0;
      wr(CT, 16'h0000);
   endtask : t_wake

   task automatic t_heat(input logic h);
      sense.canHot <= h;
      sense.linHot <= {3{h}};
      sense.auxHot <= h;
      sense.buckPrewarn <= h;
      w(6);
      wr(ST, 16'h03ff);
      wr(FT, 16'h0055);
      rd(FT);
      `CHK(q[7:0], {4{1'b0, h}})
      rd(ST);
      `CHK(q[9:7], {3{h}})
   endtask : t_heat

   task automatic t_thermal;
      canActive <= 1'b1;
      linActive <= 3'h7;
      wr(CT, 16'h0043);
      `CHK(auxRailEnable, 1'b1)
      t_heat(1'b1);
      `CHK({canTxDisable, linTxDisable, auxRailEnable}, 5'h1e)
      t_heat(1'b0);
      `CHK({canTxDisable, linTxDisable, auxRailEnable}, 5'h00)
      rd(CT);
      `CHK(q[10:8], MODE_NORMAL)
      wr(ST, 16'h03ff);
      wr(FT, 16'h0055);
      rd(FT);
      `CHK(q[7:0], 8'h00)
      sense.linSupplyLow <= 1'b1;
      w(6);
      `CHK(linTxDisable, 3'h7)
      wr(ST, 16'h03ff);
      rd(ST);
      `CHK(q[9:0], 10'h002)
      sense.linSupplyLow <= 1'b0;
      w(4);
      wr(ST, 16'h0002);
      rd(ST);
      `CHK(q[`FL_LIN_LOW], 1'b0)
   endtask : t_thermal

   task automatic t_power_loss;
      wr(CT, 16'h0043);
      sense.supplyAbovePor <= 1'b0;
      w(5);
      `CHK({link.resetOutN, auxRailEnable}, 2'b00)
      sense.supplyAbovePor <= 1'b1;
      w(RDLY + 10);
      rd(CT);
      `CHK(q[10:2], {MODE_INIT, 6'h00})
      rd(ST);
      `CHK(q[`FL_POR], 1'b1)
   endtask : t_power_loss

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      test_done();
   end

   initial begin
      sense = '0;
      sense.supplyAbovePor = 1'b1;
      sense.mainAboveRt = 3'h7;
      w(3);
      rst_n <= 1'b1;
      t_power_up();
      t_uv();
      t_short();
      t_ov();
      t_wake();
      t_thermal();
      t_power_loss();
      test_done();
   end
endmodule : test_supply_thermal_supervisor
